// [hdl/serial_status_pkg.sv]
// constants shared by the serial status flag logic
// assumes a single 125 MHz system clock and synchronous active-low reset
package serial_status_pkg;
    localparam int  DATA_W          = 8;
    localparam int  FLAG_N          = 6;
    localparam int  PAR_BIT         = 5;
    localparam int  FRM_BIT         = 4;
    localparam int  OVR_BIT         = 3;
    localparam int  RXF_BIT         = 2;
    localparam int  TXE_BIT         = 1;
    localparam int  TXEND_BIT       = 0;
    localparam logic RX_FULL_RST    = 1'h0;
    localparam logic TX_EMPTY_RST   = 1'h1;
    localparam logic TX_END_RST     = 1'h1;
    localparam logic ERR_RST        = 1'h0;
    localparam logic MP_RST         = 1'h0;
    localparam logic PARITY_EVEN    = 1'h0;
    localparam logic PARITY_ODD     = 1'h1;
    localparam logic STOP_GOOD      = 1'h1;
    localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// [hdl/w0c_flag.sv]
// one status flag that hardware sets and software clears by read-one then write-zero
// assumes read and write strobes are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ns
module w0c_flag (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic rst_val,
    input  wire logic set_evt,
    input  wire logic hw_clr,
    input  wire logic rd_stb,
    input  wire logic wr_stb,
    input  wire logic wr_val,
    output logic      flag
);
    logic armed_reg;

    // a read that saw one arms the clear; any write disarms
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            armed_reg <= 1'h0;
        end else if (wr_stb) begin
            armed_reg <= 1'h0;
        end else if (rd_stb && flag) begin
            armed_reg <= 1'h1;
        end
    end

    // set wins over every clear; writing one does nothing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag <= rst_val;
        end else if (set_evt) begin
            flag <= 1'h1;
        end else if (hw_clr || (wr_stb && !wr_val && armed_reg && flag)) begin // RQ2 RQ4 RQ6 RQ15
            flag <= 1'h0;
        end
    end
endmodule

// [hdl/serial_status_flags.sv]
// status flags of an asynchronous serial interface
// assumes shift paths give one-cycle completion pulses; status is read and written as one word of strobes
`timescale 1ns/1ns
// Notes on behaviour
// (RQ1) parity error set when ones of data plus parity disagree with parity select
// (RQ2) parity error cleared by writing zero after reading it as one
// (RQ3) framing error set when final stop bit is sampled as zero
// (RQ4) framing error cleared only by write zero after read of one
// (RQ5) overrun set when reception completes while receive full is still one
// (RQ6) overrun cleared by write zero after reading it as one
// (RQ7) error-free reception loads holding register and sets receive full
// (RQ8) receive full clears on holding register read or write-zero after read-one
// (RQ9) transmit empty clears on holding register write or write-zero after read-one
// (RQ10) transmit empty set on move to shift register or when transmit enable drops
// (RQ11) transmit end set when last bit sent while transmit empty is one
// (RQ12) transmit end cleared when software writes the transmit holding register
// (RQ13) chosen multiprocessor bit is sent with each transmitted character
// (RQ14) multiprocessor bit of last received character is readable
// (RQ15) writing one or unarmed zero to a flag leaves it unchanged
// (RQ16) software should read receive data before the next character completes
module serial_status_flags
    import serial_status_pkg::*;
(
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 parity_select,
    input  wire logic                                 tx_enable,
    input  wire logic                                 mp_bit_to_send,
    input  wire logic                                 rx_done,
    input  wire logic [serial_status_pkg::DATA_W-1:0] rx_shift_reg,
    input  wire logic                                 rx_parity_bit,
    input  wire logic                                 rx_parity_en,
    input  wire logic                                 rx_stop_bit,
    input  wire logic                                 rx_mp_bit,
    input  wire logic                                 rx_data_rd,
    input  wire logic                                 tx_data_wr,
    input  wire logic [serial_status_pkg::DATA_W-1:0] tx_data_in,
    input  wire logic                                 tx_load,
    input  wire logic                                 tx_last_bit,
    input  wire logic                                 status_rd,
    input  wire logic                                 status_wr,
    input  wire logic [5:0]                           status_wdata,
    output logic      [serial_status_pkg::DATA_W-1:0] rx_holding_reg,
    output logic      [serial_status_pkg::DATA_W-1:0] tx_holding_reg,
    output logic      [serial_status_pkg::DATA_W-1:0] tx_shift_data,
    output logic                                      tx_mp_bit,
    output logic                                      mp_bit_received,
    output logic                                      parity_err_flag,
    output logic                                      framing_err_flag,
    output logic                                      overrun_flag,
    output logic                                      rx_full_flag,
    output logic                                      tx_empty_flag,
    output logic                                      tx_end_flag
);
    import serial_status_pkg::*;

    // ***************************************
    // receive completion decode
    // ***************************************
    logic parity_sum;
    logic parity_bad;
    logic stop_bad;
    logic overrun_evt;
    logic rx_good;

    // data plus parity bit folded to one bit: one means an odd count of ones
    assign parity_sum  = ^{rx_shift_reg, rx_parity_bit};
    // parity is only judged when the frame carries a parity bit
    assign parity_bad  = rx_done && rx_parity_en && (parity_sum != parity_select); // RQ1
    assign stop_bad    = rx_done && (rx_stop_bit != STOP_GOOD); // RQ3
    // a completion while the last character is still unread
    assign overrun_evt = rx_done && rx_full_flag; // RQ5
    // only a clean completion into an empty holding register loads it
    assign rx_good     = rx_done && !parity_bad && !stop_bad && !overrun_evt; // RQ7

    // ***************************************
    // receive data registers
    // ***************************************
    // on overrun the unread character is kept and the new one is dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_holding_reg <= DATA_RST;
        end else if (rx_good) begin
            rx_holding_reg <= rx_shift_reg; // RQ7
        end
    end

    // the multiprocessor bit travels with the character that carried it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mp_bit_received <= MP_RST;
        end else if (rx_good) begin
            mp_bit_received <= rx_mp_bit; // RQ14
        end
    end

    // ***************************************
    // transmit data registers
    // ***************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_holding_reg <= DATA_RST;
        end else if (tx_data_wr) begin
            tx_holding_reg <= tx_data_in;
        end
    end

    // the shift path keeps its copy; later holding writes wait for the next load
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_shift_data <= DATA_RST;
        end else if (tx_load) begin
            tx_shift_data <= tx_holding_reg;
        end
    end

    // captured at load, so a change of the chosen bit waits for the next character
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_mp_bit <= MP_RST;
        end else if (tx_load) begin
            tx_mp_bit <= mp_bit_to_send; // RQ13
        end
    end

    // ***************************************
    // transmit enable edge
    // ***************************************
    logic tx_en_reg;
    logic tx_en_fall;

    // resets to the idle level so that no false fall follows reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_en_reg <= 1'h0;
        end else begin
            tx_en_reg <= tx_enable;
        end
    end
    assign tx_en_fall = tx_en_reg && !tx_enable; // RQ10

    // ***************************************
    // flag vectors, one bit per flag
    // ***************************************
    logic [FLAG_N-1:0] set_vec;
    logic [FLAG_N-1:0] hwclr_vec;
    logic [FLAG_N-1:0] rst_vec;
    logic [FLAG_N-1:0] flag_vec;
    logic              tx_empty_evt;
    logic              tx_end_evt;

    // ***************************************
    // receive flag events
    // ***************************************
    assign set_vec[PAR_BIT]   = parity_bad; // RQ1
    assign set_vec[FRM_BIT]   = stop_bad; // RQ3
    assign set_vec[OVR_BIT]   = overrun_evt; // RQ5
    assign set_vec[RXF_BIT]   = rx_good; // RQ7

    // ***************************************
    // transmit flag events
    // ***************************************
    assign tx_empty_evt       = tx_load || tx_en_fall; // RQ10
    // the end of a character only counts once the holding register is empty
    assign tx_end_evt         = tx_last_bit && tx_empty_flag; // RQ11
    assign set_vec[TXE_BIT]   = tx_empty_evt; // RQ10
    assign set_vec[TXEND_BIT] = tx_end_evt; // RQ11

    // ***************************************
    // flag side-effect clears
    // ***************************************
    // error flags have no side-effect clear; only read-one then write-zero
    assign hwclr_vec[PAR_BIT]   = 1'h0; // RQ2
    assign hwclr_vec[FRM_BIT]   = 1'h0; // RQ4
    assign hwclr_vec[OVR_BIT]   = 1'h0; // RQ6
    // reading the character frees the holding register
    assign hwclr_vec[RXF_BIT]   = rx_data_rd; // RQ8
    // new transmit data means the holding register is full and sending resumes
    assign hwclr_vec[TXE_BIT]   = tx_data_wr; // RQ9
    assign hwclr_vec[TXEND_BIT] = tx_data_wr; // RQ12

    // ***************************************
    // flag reset values
    // ***************************************
    // the transmit side leaves reset idle: empty and ended
    assign rst_vec[PAR_BIT]   = ERR_RST;
    assign rst_vec[FRM_BIT]   = ERR_RST;
    assign rst_vec[OVR_BIT]   = ERR_RST;
    assign rst_vec[RXF_BIT]   = RX_FULL_RST;
    assign rst_vec[TXE_BIT]   = TX_EMPTY_RST;
    assign rst_vec[TXEND_BIT] = TX_END_RST;

    // ***************************************
    // flag cells
    // ***************************************
    // all cells share the status strobes, so any status write disarms every flag
    genvar i;
    generate
        for (i = 0; i < FLAG_N; i++) begin : g_flag
            w0c_flag u_flag (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .rst_val (rst_vec[i]),
                .set_evt (set_vec[i]),
                .hw_clr  (hwclr_vec[i]),
                .rd_stb  (status_rd),
                .wr_stb  (status_wr),
                .wr_val  (status_wdata[i]), // RQ15
                .flag    (flag_vec[i])
            );
        end
    endgenerate

    // ***************************************
    // flag outputs
    // ***************************************
    assign parity_err_flag  = flag_vec[PAR_BIT];
    assign framing_err_flag = flag_vec[FRM_BIT];
    assign overrun_flag     = flag_vec[OVR_BIT];
    assign rx_full_flag     = flag_vec[RXF_BIT];
    assign tx_empty_flag    = flag_vec[TXE_BIT];
    assign tx_end_flag      = flag_vec[TXEND_BIT];
endmodule

// [testbench/serial_status_props.sv]
// assertions on the serial status flag ports
// assumes bind to serial_status_flags, one clock
`timescale 1ns/1ns
module serial_status_props (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       parity_select,
    input wire logic       tx_enable,
    input wire logic       mp_bit_to_send,
    input wire logic       rx_done,
    input wire logic       rx_parity_bit,
    input wire logic       rx_parity_en,
    input wire logic       rx_stop_bit,
    input wire logic       rx_mp_bit,
    input wire logic       rx_data_rd,
    input wire logic       tx_data_wr,
    input wire logic       tx_load,
    input wire logic       tx_last_bit,
    input wire logic       status_wr,
    input wire logic       tx_mp_bit,
    input wire logic       mp_bit_received,
    input wire logic       parity_err_flag,
    input wire logic       framing_err_flag,
    input wire logic       overrun_flag,
    input wire logic       rx_full_flag,
    input wire logic       tx_empty_flag,
    input wire logic       tx_end_flag,
    input wire logic [7:0] rx_shift_reg,
    input wire logic [7:0] rx_holding_reg,
    input wire logic [5:0] status_wdata
);
    wire bad = rx_parity_en && ((^rx_shift_reg ^ rx_parity_bit) != parity_select);
    wire good = rx_done && rx_stop_bit && !rx_full_flag && !bad;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    par_set_a: assert property (rx_done && bad |=> parity_err_flag) else $error("parity");
    frm_set_a: assert property (rx_done && !rx_stop_bit |=> framing_err_flag) else $error("framing");
    ovr_set_a: assert property (rx_done && rx_full_flag |=> overrun_flag) else $error("overrun");
    rx_load_a: assert property (good |=> rx_full_flag && rx_holding_reg == $past(rx_shift_reg)
        && mp_bit_received == $past(rx_mp_bit)) else $error("rx load");
    wr_one_a: assert property (status_wr && status_wdata[5] |=> !$fell(parity_err_flag)) else $error("w1");
    rd_clr_a: assert property (rx_data_rd && !rx_done |=> !rx_full_flag) else $error("rx read");
    tx_wr_a: assert property (tx_data_wr && !tx_load && !tx_last_bit && tx_enable
        && $past(tx_enable) && $past(tx_enable, 2) |=> !tx_empty_flag && !tx_end_flag) else $error("tx wr");
    load_set_a: assert property (tx_load |=> tx_empty_flag && tx_mp_bit == $past(mp_bit_to_send))
        else $error("tx load");
    end_set_a: assert property (tx_last_bit && tx_empty_flag |=> tx_end_flag) else $error("tx end");
    en_fall_a: assert property ($past(rst_n) && $fell(tx_enable) |=> tx_empty_flag) else $error("tx off");
    cover property ($fell(tx_enable));
    cover property (good);
    cover property (rx_done && rx_full_flag);
    cover property (tx_last_bit && tx_empty_flag);
endmodule
bind serial_status_flags serial_status_props props (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .parity_select    (parity_select),
    .tx_enable        (tx_enable),
    .mp_bit_to_send   (mp_bit_to_send),
    .rx_done          (rx_done),
    .rx_parity_bit    (rx_parity_bit),
    .rx_parity_en     (rx_parity_en),
    .rx_stop_bit      (rx_stop_bit),
    .rx_mp_bit        (rx_mp_bit),
    .rx_data_rd       (rx_data_rd),
    .tx_data_wr       (tx_data_wr),
    .tx_load          (tx_load),
    .tx_last_bit      (tx_last_bit),
    .status_wr        (status_wr),
    .tx_mp_bit        (tx_mp_bit),
    .mp_bit_received  (mp_bit_received),
    .parity_err_flag  (parity_err_flag),
    .framing_err_flag (framing_err_flag),
    .overrun_flag     (overrun_flag),
    .rx_full_flag     (rx_full_flag),
    .tx_empty_flag    (tx_empty_flag),
    .tx_end_flag      (tx_end_flag),
    .rx_shift_reg     (rx_shift_reg),
    .rx_holding_reg   (rx_holding_reg),
    .status_wdata     (status_wdata)
);

// [testbench/remote_tx.sv]
// remote transmitter: hands finished characters to the receive side
// assumes the bench calls send between falling edges
`timescale 1ns/1ns
module remote_tx (
    input  wire logic sys_clk,
    output logic       rx_done,
    output logic [7:0] rx_shift_reg,
    output logic       rx_parity_bit,
    output logic       rx_parity_en,
    output logic       rx_stop_bit,
    output logic       rx_mp_bit
);
    initial {rx_done, rx_mp_bit, rx_stop_bit, rx_parity_en, rx_parity_bit, rx_shift_reg} = 13'h0000;
    // w is {mp, stop, parity enable, parity, data}; fields invert once the pulse ends
    task send(input logic [11:0] w);
        @(negedge sys_clk);
        {rx_done, rx_mp_bit, rx_stop_bit, rx_parity_en, rx_parity_bit, rx_shift_reg} = {1'b1, w};
        @(negedge sys_clk);
        {rx_done, rx_mp_bit, rx_stop_bit, rx_parity_en, rx_parity_bit, rx_shift_reg} = {1'b0, ~w};
    endtask
endmodule

// [testbench/tb.sv]
// bench for the serial status flags
// assumes flags show one cycle after each strobe
`timescale 1ns/1ns
module tb;
    logic       sys_clk = 0, rst_n = 0, parity_select = 0, tx_enable = 0, mp_bit_to_send = 0, rx_data_rd = 0;
    logic       tx_data_wr = 0, tx_load = 0, tx_last_bit = 0, status_rd = 0, status_wr = 0;
    logic [7:0] tx_data_in = 8'h00, rx_shift_reg, rx_holding_reg, tx_holding_reg, tx_shift_data;
    logic [5:0] status_wdata = 6'h00;
    logic       rx_done, rx_parity_bit, rx_parity_en, rx_stop_bit, rx_mp_bit, tx_mp_bit, mp_bit_received;
    logic       parity_err_flag, framing_err_flag, overrun_flag, rx_full_flag, tx_empty_flag, tx_end_flag;
    int         bad_count = 0, checks = 0;
    wire  [7:0] f = {2'h0, parity_err_flag, framing_err_flag, overrun_flag, rx_full_flag, tx_empty_flag, tx_end_flag};
    remote_tx far (
        .sys_clk       (sys_clk),
        .rx_done       (rx_done),
        .rx_shift_reg  (rx_shift_reg),
        .rx_parity_bit (rx_parity_bit),
        .rx_parity_en  (rx_parity_en),
        .rx_stop_bit   (rx_stop_bit),
        .rx_mp_bit     (rx_mp_bit)
    );
    serial_status_flags dut (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .parity_select    (parity_select),
        .tx_enable        (tx_enable),
        .mp_bit_to_send   (mp_bit_to_send),
        .rx_done          (rx_done),
        .rx_shift_reg     (rx_shift_reg),
        .rx_parity_bit    (rx_parity_bit),
        .rx_parity_en     (rx_parity_en),
        .rx_stop_bit      (rx_stop_bit),
        .rx_mp_bit        (rx_mp_bit),
        .rx_data_rd       (rx_data_rd),
        .tx_data_wr       (tx_data_wr),
        .tx_data_in       (tx_data_in),
        .tx_load          (tx_load),
        .tx_last_bit      (tx_last_bit),
        .status_rd        (status_rd),
        .status_wr        (status_wr),
        .status_wdata     (status_wdata),
        .rx_holding_reg   (rx_holding_reg),
        .tx_holding_reg   (tx_holding_reg),
        .tx_shift_data    (tx_shift_data),
        .tx_mp_bit        (tx_mp_bit),
        .mp_bit_received  (mp_bit_received),
        .parity_err_flag  (parity_err_flag),
        .framing_err_flag (framing_err_flag),
        .overrun_flag     (overrun_flag),
        .rx_full_flag     (rx_full_flag),
        .tx_empty_flag    (tx_empty_flag),
        .tx_end_flag      (tx_end_flag)
    );
    initial forever #4 sys_clk = ~sys_clk;
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic pl(ref logic s);
        @(negedge sys_clk);
        s = 1;
        @(negedge sys_clk);
        s = 0;
    endtask
    task sw(input logic [5:0] w);
        status_wdata = w;
        pl(status_wr);
    endtask
    task t_rx;
        far.send(12'hca5);
        cmp(rx_holding_reg, 8'ha5);
        cmp(f, 8'h07);
        cmp({7'h0, mp_bit_received}, 8'h01);
        far.send(12'h45a);
        cmp(f, 8'h0f);
        cmp(rx_holding_reg, 8'ha5);
        pl(rx_data_rd);
        cmp(f, 8'h0b);
        sw(6'h00);
        cmp(f, 8'h0b);
        pl(status_rd);
        sw(6'h3f);
        sw(6'h01);
        cmp(f, 8'h0b);
        pl(status_rd);
        sw(6'h01);
        cmp(f, 8'h01);
    endtask
    task t_err;
        for (int p = 0; p < 2; p++) begin
            parity_select = p[0];
            far.send({3'h3, ~p[0], 8'ha5});
            cmp(f, 8'h21);
            pl(status_rd);
            sw(6'h1f);
            cmp(f, 8'h01);
        end
        far.send(12'h0a5);
        cmp(f, 8'h11);
        pl(status_rd);
        sw(6'h2f);
        cmp(f, 8'h01);
    endtask
    task t_tx;
        tx_enable = 1;
        mp_bit_to_send = 1;
        tx_data_in = 8'h3c;
        pl(tx_data_wr);
        cmp(f, 8'h00);
        cmp(tx_holding_reg, 8'h3c);
        pl(tx_load);
        cmp(f, 8'h02);
        cmp(tx_shift_data, 8'h3c);
        cmp({7'h0, tx_mp_bit}, 8'h01);
        pl(tx_last_bit);
        cmp(f, 8'h03);
        pl(tx_data_wr);
        pl(tx_last_bit);
        cmp(f, 8'h00);
        mp_bit_to_send = 0;
        pl(tx_load);
        cmp({7'h0, tx_mp_bit}, 8'h00);
        pl(tx_data_wr);
        tx_enable = 0;
        repeat (2) @(negedge sys_clk);
        cmp(f, 8'h02);
    endtask
    // software serves each character before the next one completes
    task t_svc;
        parity_select = 0;
        far.send(12'h63c);
        cmp(f, 8'h06);
        cmp(rx_holding_reg, 8'h3c);
        cmp({7'h0, mp_bit_received}, 8'h00);
        pl(rx_data_rd);
        far.send(12'hec3);
        cmp(f, 8'h06);
        cmp(rx_holding_reg, 8'hc3);
        cmp({7'h0, mp_bit_received}, 8'h01);
    endtask
    task wrap_up;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1;
        cmp(f, 8'h03);
        t_rx;
        t_err;
        t_tx;
        t_svc;
        wrap_up;
    end
endmodule
